/* hw/llmr_pkg.sv */
// Package for the ladder-logic scan engine with master reset.
// Assumes a single 20 MHz clock domain and no software-visible registers.
package llmr_pkg;

  localparam int NUM_INPUTS   = 16;
  localparam int NUM_BASE_Q   = 8;
  localparam int NUM_EXP_Q    = 8;
  localparam int NUM_MARKERS  = 16;
  localparam int MAX_SERIES   = 3;
  localparam int NUM_RUNGS    = 32;
  localparam int RUNG_IDX_W   = 5;

  // Operand space: 0-15 inputs, 16-23 base out, 24-31 exp out, 32-47 M, 48-63 N
  localparam int OPND_W       = 6;
  localparam logic [5:0] OPND_Q_BASE = 6'h10;
  localparam logic [5:0] OPND_S_BASE = 6'h18;
  localparam logic [5:0] OPND_M_BASE = 6'h20;
  localparam logic [5:0] OPND_N_BASE = 6'h30;

  // Target space: 0-7 Q, 8-15 S, 16-31 M, 32-47 N, 48-50 reset coils
  localparam int TGT_W        = 6;
  localparam logic [5:0] TGT_S_BASE  = 6'h08;
  localparam logic [5:0] TGT_M_BASE  = 6'h10;
  localparam logic [5:0] TGT_N_BASE  = 6'h20;
  localparam logic [5:0] TGT_Z_BASE  = 6'h30;
  localparam int NUM_TARGETS  = 51;

  // Contact field: use, negate (break), operand
  localparam int CT_W         = 8;
  localparam int CT_USE_BIT   = 7;
  localparam int CT_NEG_BIT   = 6;

  // Rung word: [31] valid, [30] parallel-with-previous, [29:27] coil kind,
  // [26:21] target, [20:0] three contact fields (unused field = bridge)
  localparam int RW_W         = 32;
  localparam int RW_VALID_BIT = 31;
  localparam int RW_PAR_BIT   = 30;
  localparam int RW_KIND_LSB  = 27;
  localparam int RW_TGT_LSB   = 21;
  localparam int RW_C0_LSB    = 0;
  localparam int RW_FIELD_W   = 7;

  typedef enum logic [2:0] {
    LLMR_COIL_NORMAL,
    LLMR_COIL_NEGATED,
    LLMR_COIL_SET,
    LLMR_COIL_RESET,
    LLMR_COIL_IMPULSE,
    LLMR_COIL_NONE
  } llmr_coil_e;

  localparam logic [RW_W-1:0] RUNG_RESET_VAL = 32'h0000_0000;

endpackage

/* hw/llmr_core.sv */
// Cyclic rung scan engine with three master reset coils.
// Assumes field inputs are asynchronous pins; program loaded from a static port.
`timescale 1ns/1ps

// Functional notes
// - Outputs reset coil clears Q and S
// - Markers reset coil clears M and N
// - Combined reset coil clears Q, S, M and N
// - Reset acts on edge or level one
// - Master reset overrides all other writes
// - Reset contacts mirror their own coil
// - Contact 1 closes make, opens break
// - Break contact conducts on zero input
// - Negated coil inverts rung result
// - At most three series contacts per rung
// - Series make AND, series break NOR
// - Parallel make OR, parallel break NAND
// - Parallel breaks on negated coil AND
// - Parallel makes on negated coil NOR
// - Two series pairs paralleled give XOR
// - Own contact latches until stop opens
// - Later coil wins within a scan
// - Impulse coil toggles on one
// - Fully bridged rung keeps coil on
module llmr_core (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst_b,
  // Field contacts
  input  wire logic [llmr_pkg::NUM_INPUTS-1:0]          field_in,
  // Program, one word per rung
  input  wire logic [llmr_pkg::NUM_RUNGS*llmr_pkg::RW_W-1:0] program_words,
  // Relay, marker and reset contact outputs, and scan_done
  output logic      [llmr_pkg::NUM_BASE_Q-1:0]          base_out,
  output logic      [llmr_pkg::NUM_EXP_Q-1:0]           exp_out,
  output logic      [llmr_pkg::NUM_MARKERS-1:0]         marker_m,
  output logic      [llmr_pkg::NUM_MARKERS-1:0]         marker_n,
  output logic      [2:0]                               reset_contacts,
  output logic                                          scan_done
);

  localparam int NT = llmr_pkg::NUM_TARGETS;

  logic [llmr_pkg::NUM_INPUTS-1:0]  in_meta;
  logic [llmr_pkg::NUM_INPUTS-1:0]  in_sync;
  logic [llmr_pkg::NUM_INPUTS-1:0]  in_img;
  logic [NT-1:0]                    pub;
  logic [NT-1:0]                    work;
  logic [llmr_pkg::RUNG_IDX_W-1:0]  rung;
  logic                             path_acc;
  logic [llmr_pkg::RW_W-1:0]        rw;
  logic                             rung_cond;
  logic                             path_now;
  logic                             last_of_group;
  logic [NT-1:0]                    next_work;
  logic [NT-1:0]                    clr_mask;
  logic [2:0]                       z_now;
  logic [2:0]                       z_prev;
  logic [2:0]                       z_rise;
  logic                             scan_end;
  logic [llmr_pkg::RUNG_IDX_W-1:0]  rung_nx;

  // Operand fetch from the published image and the scan-start input image
  function automatic logic opnd_val(
    input logic [llmr_pkg::OPND_W-1:0] op,
    input logic [llmr_pkg::NUM_INPUTS-1:0] ins,
    input logic [NT-1:0] img
  );
    logic v;
    v = 1'b0;
    if (op < llmr_pkg::OPND_Q_BASE)
      v = ins[op[3:0]];
    else if (op < llmr_pkg::OPND_M_BASE)
      v = img[{2'h0, op[3:0]}];
    else if (op < llmr_pkg::OPND_N_BASE)
      v = img[6'(llmr_pkg::TGT_M_BASE) + {2'h0, op[3:0]}];
    else
      v = img[6'(llmr_pkg::TGT_N_BASE) + {2'h0, op[3:0]}];
    return v;
  endfunction

  // Contact field evaluation
  function automatic logic contact_ok(
    input logic [llmr_pkg::RW_FIELD_W-1:0] f,
    input logic [llmr_pkg::NUM_INPUTS-1:0] ins,
    input logic [NT-1:0] img
  );
    logic v;
    v = 1'b1;
    // unused field bridges
    // Bit 5 is the negate flag, so contacts reach operands 0-31 only;
    // markers are written by coils but cannot be read back as contacts
    if (f[llmr_pkg::RW_FIELD_W-1])
      v = opnd_val({1'b0, f[4:0]}, ins, img) ^ f[llmr_pkg::RW_FIELD_W-2];
    return v;
  endfunction

  // Synchronise field inputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_meta <= '0;
      in_sync <= '0;
    end
    else
    begin
      in_meta <= field_in;
      in_sync <= in_meta;
    end
  end

  assign rw = program_words[rung*llmr_pkg::RW_W +: llmr_pkg::RW_W];

  always_comb
  begin
    rung_cond = 1'b1;
    for (int k = 0; k < llmr_pkg::MAX_SERIES; k++)
      rung_cond = rung_cond & contact_ok(
        rw[llmr_pkg::RW_C0_LSB + k*llmr_pkg::RW_FIELD_W +: llmr_pkg::RW_FIELD_W],
        in_img, pub);
  end

  assign scan_end = (rung == llmr_pkg::RUNG_IDX_W'(llmr_pkg::NUM_RUNGS - 1));

  // Parallel rungs OR together; the coil is written on the last of a group
  always_comb
  begin
    // Wraps to rung 0 on the last rung, which scan_end masks off
    rung_nx = rung + 1'b1;
    if (rw[llmr_pkg::RW_PAR_BIT])
    begin
      path_now = path_acc | rung_cond;
    end
    else
    begin
      path_now = rung_cond;
    end
    last_of_group = scan_end ||
      !program_words[rung_nx*llmr_pkg::RW_W + llmr_pkg::RW_PAR_BIT];
  end

  // Next state of one coil; unknown kinds leave it alone
  function automatic logic coil_next(
    input logic [2:0] kind,
    input logic       old_val,
    input logic       path
  );
    logic v;
    v = old_val;
    case (llmr_pkg::llmr_coil_e'(kind))
      llmr_pkg::LLMR_COIL_NORMAL:
      begin
        v = path;
      end
      llmr_pkg::LLMR_COIL_NEGATED:
      begin
        v = ~path;
      end
      llmr_pkg::LLMR_COIL_SET:
      begin
        v = old_val | path;
      end
      llmr_pkg::LLMR_COIL_RESET:
      begin
        v = old_val & ~path;
      end
      llmr_pkg::LLMR_COIL_IMPULSE:
      begin
        v = old_val ^ path;
      end
      default:
      begin
        v = old_val;
      end
    endcase
    return v;
  endfunction

  // Targets cleared by a set of master reset coils
  function automatic logic [NT-1:0] reset_mask(
    input logic [2:0] z
  );
    logic [NT-1:0] m;
    m = '0;
    if (z[0] | z[2])
    begin
      m[llmr_pkg::TGT_M_BASE-1:0] = '1;
    end
    if (z[1] | z[2])
    begin
      m[llmr_pkg::TGT_Z_BASE-1:llmr_pkg::TGT_M_BASE] = '1;
    end
    return m;
  endfunction

  // Coil write of the current rung into the working image
  always_comb
  begin
    logic [llmr_pkg::TGT_W-1:0] t;
    t = rw[llmr_pkg::RW_TGT_LSB +: llmr_pkg::TGT_W];
    next_work = work;
    if (rw[llmr_pkg::RW_VALID_BIT] && last_of_group && t < 6'(NT))
    begin
      next_work[t] = coil_next(rw[llmr_pkg::RW_KIND_LSB +: 3], work[t], path_now);
    end
  end

  // Reset coils as they stand after the last rung of the scan
  always_comb
  begin
    z_now = next_work[llmr_pkg::TGT_Z_BASE +: 3];
    // A rising edge is also a level one, so the level alone would do;
    // the edge term keeps both triggers visible
    z_rise = z_now & ~z_prev;
    clr_mask = reset_mask(z_now | z_rise);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rung     <= '0;
      path_acc <= 1'b0;
    end
    else
    begin
      rung     <= rung + 1'b1;
      path_acc <= path_now;
    end
  end

  // Working image carries coil states from rung to rung
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      work <= '0;
    end
    else if (scan_end)
    begin
      work <= next_work & ~clr_mask;
    end
    else
    begin
      work <= next_work;
    end
  end

  // Published and input images change only between scans
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pub    <= '0;
      in_img <= '0;
      z_prev <= '0;
    end
    else if (scan_end)
    begin
      pub    <= next_work & ~clr_mask;
      in_img <= in_sync;
      z_prev <= z_now;
    end
  end

  // One-cycle marker of a finished scan
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_done <= 1'b0;
    end
    else
    begin
      scan_done <= scan_end;
    end
  end

  // Outputs are registered copies of the published image, one cycle behind it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      base_out       <= '0;
      exp_out        <= '0;
      marker_m       <= '0;
      marker_n       <= '0;
      reset_contacts <= '0;
    end
    else
    begin
      base_out <= pub[llmr_pkg::TGT_S_BASE-1:0];
      exp_out  <= pub[llmr_pkg::TGT_M_BASE-1:llmr_pkg::TGT_S_BASE];
      marker_m <= pub[llmr_pkg::TGT_N_BASE-1:llmr_pkg::TGT_M_BASE];
      marker_n <= pub[llmr_pkg::TGT_Z_BASE-1:llmr_pkg::TGT_N_BASE];
      reset_contacts <= pub[llmr_pkg::TGT_Z_BASE +: 3];
    end
  end

endmodule

/* verif/llmr_core_asserts.sv */
// Port checker for the rung scan engine.
// Assumes one clock and an active-low reset.
`timescale 1ns/1ps
module llmr_core_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Published image and scan_done
  input wire logic [7:0]  base_out,
  input wire logic [7:0]  exp_out,
  input wire logic [15:0] marker_m,
  input wire logic [15:0] marker_n,
  input wire logic [2:0]  reset_contacts,
  input wire logic        scan_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  scan_period_a: assert property (scan_done |-> ##32 scan_done)
    else $error("bad scan period");
  done_pulse_a: assert property (scan_done |=> !scan_done)
    else $error("long scan_done");
  out_publish_a: assert property ($changed({base_out, exp_out}) |-> $past(scan_done))
    else $error("outputs moved mid scan");
  mark_publish_a: assert property ($changed({marker_m, marker_n}) |-> $past(scan_done))
    else $error("markers moved mid scan");
  out_clear_a: assert property (reset_contacts[0] |-> ~|{base_out, exp_out})
    else $error("outputs not cleared");
  mark_clear_a: assert property (reset_contacts[1] |-> ~|{marker_m, marker_n})
    else $error("markers not cleared");
  all_clear_a: assert property (reset_contacts[2]
    |-> ~|{base_out, exp_out, marker_m, marker_n}) else $error("not all cleared");
  contact_hold_a: assert property (!$past(scan_done) |-> $stable(reset_contacts))
    else $error("contacts moved mid scan");
  cover property (reset_contacts[0]);
  cover property (reset_contacts[1]);
  cover property (reset_contacts[2]);
endmodule

bind llmr_core llmr_core_asserts chk_i (.clk, .rst_b, .base_out, .exp_out, .marker_m,
  .marker_n, .reset_contacts, .scan_done);

/* verif/llmr_field.sv */
// Field switch bank wired to the core inputs.
// Assumes the bench sets wanted levels at the falling edge.
`timescale 1ns/1ps
module llmr_field (
  // Clock
  input wire logic        clk,
  // Wanted switch levels
  input wire logic [15:0] want,
  // Contacts seen by the core
  output logic     [15:0] field_in
);
  initial field_in = 16'h0000;
  always @(negedge clk) field_in <= want;
endmodule

/* verif/test_ladder_logic_master_reset.sv */
// Self-checking bench for the rung scan engine.
// Assumes the core, its checker and the field switch model.
`timescale 1ns/1ps
module test_ladder_logic_master_reset;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic [15:0]   want = 16'h0000;
  logic [15:0]   field_in, marker_m, marker_n, v;
  logic [1023:0] pw = '0;
  logic [7:0]    base_out, exp_out, eb, ee;
  logic [2:0]    reset_contacts;
  logic          scan_done, q7 = 1'b0, s1 = 1'b0;
  int            n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'h6703;

  always #25 clk = ~clk;

  llmr_field fld (.clk, .want, .field_in);
  llmr_core uut (.clk, .rst_b, .field_in, .program_words(pw), .base_out, .exp_out,
    .marker_m, .marker_n, .reset_contacts, .scan_done);

  function automatic logic [6:0] ct(int op, int ng);
    return {1'b1, ng[0], op[4:0]};
  endfunction

  function automatic logic [31:0] rw(int p, int k, int t, logic [6:0] a = 0, b = 0, c = 0);
    return {1'b1, p[0], k[2:0], t[5:0], c, b, a};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Expected relay image once inputs have settled
  task automatic model();
    eb = {1'b0, v[0] ^ v[1], 1'b1, ~v[0], ~&v[2:0], |v[2:0], ~|v[2:0], &v[2:0]};
    q7 = v[4] ? 1'b0 : (v[3] | q7);
    s1 = ~v[12] & (v[11] | s1);
    eb[7] = q7;
    ee = {6'h00, s1, v[8]};
    if (v[5] | v[7])
    begin
      eb = 8'h00;
      ee = 8'h00;
      q7 = 1'b0;
      s1 = 1'b0;
    end
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial
  begin
    for (int k = 0; k < 3; k++)
    begin
      pw[(2+k)*32+:32] = rw(k > 0, 0, 2, ct(k, 0));
      pw[(5+k)*32+:32] = rw(k > 0, 0, 3, ct(k, 1));
      pw[(16+k)*32+:32] = rw(0, 0, 48 + k, ct(5 + k, 0));
    end
    pw[0+:32] = rw(0, 0, 0, ct(0, 0), ct(1, 0), ct(2, 0));
    pw[32+:32] = rw(0, 0, 1, ct(0, 1), ct(1, 1), ct(2, 1));
    pw[256+:32] = rw(0, 1, 4, ct(0, 0));
    pw[288+:32] = rw(0, 0, 5);
    pw[320+:32] = rw(0, 0, 6, ct(0, 0), ct(1, 1));
    pw[352+:32] = rw(1, 0, 6, ct(0, 1), ct(1, 0));
    pw[384+:32] = rw(0, 1, 16, ct(0, 1));
    pw[416+:32] = rw(1, 1, 16, ct(1, 1));
    pw[448+:32] = rw(0, 2, 7, ct(3, 0));
    pw[480+:32] = rw(0, 3, 7, ct(4, 0));
    pw[608+:32] = rw(0, 0, 8, ct(8, 0));
    pw[640+:32] = rw(0, 0, 32, ct(9, 0));
    pw[672+:32] = rw(0, 0, 9, ct(11, 0), ct(12, 1));
    pw[704+:32] = rw(1, 0, 9, ct(25, 0), ct(12, 1));
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    for (int n = 0; n < 60; n++)
    begin
      @(negedge clk);
      v = 16'($random(seed));
      if (n % 4 != 3)
        v[7:5] = 3'b000;
      want <= v;
      repeat (3) @(posedge scan_done);
      @(posedge clk);
      #1;
      model();
      chk(16'(base_out), 16'(eb));
      chk(16'(exp_out), 16'(ee));
      chk(marker_m, (v[6] | v[7]) ? 16'h0 : {15'h0, v[0] & v[1]});
      chk(marker_n, (v[6] | v[7]) ? 16'h0 : {15'h0, v[9]});
      chk(16'(reset_contacts), 16'(v[7:5]));
    end
    @(negedge clk);
    rst_b = 1'b0;
    #1;
    chk({base_out, exp_out}, 16'h0000);
    report_and_stop();
  end
endmodule
